// [fiap_pkg.sv]
// constants for the flash in-application programming mailbox sequencer
package fiap_pkg;
	// special function register addresses
	localparam logic [7:0] FIAP_ADDR_KEY_FIRST  = 8'h97;
	localparam logic [7:0] FIAP_ADDR_COMMAND    = 8'hb2;
	localparam logic [7:0] FIAP_ADDR_KEY_SECOND = 8'hc4;
	localparam logic [7:0] FIAP_ADDR_CONFIG     = 8'hb1;
	localparam logic [7:0] FIAP_ADDR_ADDR_HIGH  = 8'hb3;
	localparam logic [7:0] FIAP_ADDR_ADDR_LOW   = 8'hb4;
	localparam logic [7:0] FIAP_ADDR_DATA       = 8'hb5;
	localparam logic [7:0] FIAP_ADDR_STATUS     = 8'hb6;
	// feed keys
	localparam logic [7:0] FIAP_KEY_FIRST  = 8'ha2;
	localparam logic [7:0] FIAP_KEY_SECOND = 8'hdf;
	// fields
	localparam int FIAP_CFG_IAP_EN_BIT   = 6;
	localparam int FIAP_ST_BUSY_BIT      = 7;
	localparam int FIAP_ST_FAIL_BIT      = 0;
	localparam int FIAP_PAGE_COUNT       = 5;
	// commands (low seven bits)
	localparam logic [6:0] FIAP_CMD_CHIP_ERASE  = 7'h01;
	localparam logic [6:0] FIAP_CMD_PART0_ERASE = 7'h0d;
	localparam logic [6:0] FIAP_CMD_SECTOR_ERASE = 7'h0b;
	localparam logic [6:0] FIAP_CMD_BYTE_PROG   = 7'h0e;
	localparam logic [6:0] FIAP_CMD_BYTE_VERIFY = 7'h0c;
	localparam logic [6:0] FIAP_CMD_SECURE_PAGE = 7'h03;
	localparam logic [6:0] FIAP_CMD_OPTION      = 7'h08;
	localparam logic [6:0] FIAP_CMD_IDENTIFICATION_READ     = 7'h07;
	localparam logic [7:0] FIAP_ERASE_KEY       = 8'h55;
	localparam logic [7:0] FIAP_SECURE_BASE     = 8'h90;
	localparam logic [7:0] FIAP_OPT_CLK_DOUBLE  = 8'he0;
	localparam logic [7:0] FIAP_ID_ADDR_MFR     = 8'h30;
	localparam logic [7:0] FIAP_ID_ADDR_DEV     = 8'h31;
	localparam logic [7:0] FIAP_ID_ADDR_EXT     = 8'h32;
	// reset values
	localparam logic [7:0] FIAP_CONFIG_RESET    = 8'h00;
	localparam logic [4:0] FIAP_PAGE_SEC_RESET  = 5'h1f;
	localparam logic [7:0] FIAP_ERASED_BYTE     = 8'hff;
	localparam logic [15:0] FIAP_BOOT_LARGE     = 16'h4000;
	localparam logic [15:0] FIAP_BOOT_SMALL     = 16'h2000;
	// timing: durations in microseconds, counted in ticks of the internal timing oscillator
	localparam int FIAP_CLK_MHZ         = 100;
	localparam int FIAP_PROG_TIME_US    = 40;
	localparam int FIAP_ERASE_TIME_US   = 40;
	localparam int FIAP_OSC_TICK_CYC    = 10;
	localparam int FIAP_PROG_TICKS      = (FIAP_PROG_TIME_US * FIAP_CLK_MHZ + FIAP_OSC_TICK_CYC - 1) / FIAP_OSC_TICK_CYC;
	localparam int FIAP_ERASE_TICKS     = (FIAP_ERASE_TIME_US * FIAP_CLK_MHZ + FIAP_OSC_TICK_CYC - 1) / FIAP_OSC_TICK_CYC;
	localparam int FIAP_TICK_W          = 16;
	typedef enum logic [4:0] {
		FIAP_IDLE  = 5'b00001,
		FIAP_EXEC  = 5'b00010,
		FIAP_WAIT  = 5'b00100,
		FIAP_SWEEP = 5'b01000,
		FIAP_DONE  = 5'b10000
	} fiap_state_e;
endpackage

// [fiap_osc_timer.sv]
// gated timing oscillator: tick divider and duration counter
`timescale 1ns/1ps
module fiap_osc_timer #(
	parameter int TICK_CYC = 10,
	parameter int CNT_W    = 16
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             osc_on,
	input  wire logic             start,
	input  wire logic [CNT_W-1:0] ticks,
	output logic                  expired
);
	localparam int DIV_W = $clog2(TICK_CYC + 1);
	initial begin
		if (TICK_CYC < 1 || CNT_W < 2)
			$error("fiap_osc_timer: bad parameters");
	end
	logic [DIV_W-1:0] div_cnt;
	logic [CNT_W-1:0] remain;
	wire tick = osc_on && (div_cnt == DIV_W'(TICK_CYC - 1));
	wire [DIV_W-1:0] next_div = (!osc_on || tick) ? '0 : div_cnt + 1'b1;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= '0;
			remain  <= '0;
			expired <= 1'b0;
		end else begin
			div_cnt <= next_div;
			expired <= 1'b0;
			if (start)
				remain <= ticks;
			else if (tick && remain != '0) begin
				remain <= remain - 1'b1;
				expired <= (remain == CNT_W'(1));
			end
		end
	end
endmodule

// [fiap_mailbox.sv]
// flash in-application programming mailbox sequencer
`timescale 1ns/1ps
module fiap_mailbox #(
	parameter int          ADDR_W      = 14,
	parameter int          PART0_BYTES = 16384,
	parameter int          SECTOR_BYTES = 128,
	parameter bit          LARGE_PART  = 1'b1,
	parameter logic [7:0]  ID_MFR      = 8'h5a,
	parameter logic [7:0]  ID_DEV      = 8'h6b,
	parameter logic [7:0]  ID_EXT      = 8'h7c
) (
	input  wire logic                    core_clk,
	input  wire logic                    reset_n,
	input  wire logic                    sfr_wr,
	input  wire logic                    sfr_rd,
	input  wire logic [7:0]              sfr_addr,
	input  wire logic [7:0]              sfr_wdata,
	output logic      [7:0]              sfr_rdata,
	input  wire logic                    external_access_select,
	output logic                         cpu_stall,
	output logic                         osc_enable,
	output logic                         clk_from_external,
	output logic                         clock_double,
	output logic      [15:0]             boot_vector,
	output logic      [fiap_pkg::FIAP_PAGE_COUNT-1:0] page_unlocked
);
	import fiap_pkg::*;
	// arbitrary signature values; they name no real part
	initial begin
		if (PART0_BYTES > (1 << ADDR_W) || SECTOR_BYTES < 1 || PART0_BYTES % SECTOR_BYTES != 0)
			$error("fiap_mailbox: bad geometry");
	end
	localparam int PAGE_BYTES = PART0_BYTES / 4;
	localparam int SEC_W = $clog2(SECTOR_BYTES);
	logic ext_m, ext_s, rst_m, rst_s;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_m <= 1'b0;
			rst_s <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_s <= rst_m;
		end
	end
	always_ff @(posedge core_clk or negedge rst_s) begin
		if (!rst_s) begin
			ext_m <= 1'b1;
			ext_s <= 1'b1;
		end else begin
			ext_m <= external_access_select;
			ext_s <= ext_m;
		end
	end
	logic [7:0] flash_mem [0:PART0_BYTES-1];
	logic [7:0] flash_config_reg;
	logic [7:0] flash_command;
	logic [7:0] flash_addr_high;
	logic [7:0] flash_addr_low;
	logic [7:0] flash_data_reg;
	logic       fail_flag;
	logic [1:0] feed_stage;
	logic [4:0] page_sec;
	fiap_state_e state;
	logic [ADDR_W-1:0] sweep_addr;
	logic [ADDR_W-1:0] sweep_end;
	logic [FIAP_TICK_W-1:0] op_ticks;
	logic timer_start;
	logic timer_done;

	wire wr_key1 = sfr_wr && sfr_addr == FIAP_ADDR_KEY_FIRST;
	wire wr_key2 = sfr_wr && sfr_addr == FIAP_ADDR_KEY_SECOND;
	wire wr_cmd  = sfr_wr && sfr_addr == FIAP_ADDR_COMMAND;
	wire wr_cfg  = sfr_wr && sfr_addr == FIAP_ADDR_CONFIG;
	wire wr_ah   = sfr_wr && sfr_addr == FIAP_ADDR_ADDR_HIGH;
	wire wr_al   = sfr_wr && sfr_addr == FIAP_ADDR_ADDR_LOW;
	wire wr_dt   = sfr_wr && sfr_addr == FIAP_ADDR_DATA;
	wire idle    = state == FIAP_IDLE;
	wire iap_en  = flash_config_reg[FIAP_CFG_IAP_EN_BIT];
	wire [6:0] cmd = sfr_wdata[6:0];
	wire [15:0] full_addr = {flash_addr_high, flash_addr_low};
	wire [ADDR_W-1:0] tgt = full_addr[ADDR_W-1:0];
	wire addr_ok = full_addr < 16'(PART0_BYTES);
	wire [2:0] tgt_page = 3'(tgt / ADDR_W'(PAGE_BYTES));
	wire page_open = page_sec[tgt_page];
	wire key_armed = feed_stage == 2'd2;
	// launch only on a fed, enabled command write while idle
	wire launch = wr_cmd && key_armed && iap_en && idle;
	wire is_chip   = cmd == FIAP_CMD_CHIP_ERASE && flash_data_reg == FIAP_ERASE_KEY && !ext_s;
	wire is_part0  = cmd == FIAP_CMD_PART0_ERASE && flash_data_reg == FIAP_ERASE_KEY;
	wire is_sector = cmd == FIAP_CMD_SECTOR_ERASE && addr_ok && page_open;
	wire is_prog   = cmd == FIAP_CMD_BYTE_PROG && addr_ok && page_open;
	wire is_verify = cmd == FIAP_CMD_BYTE_VERIFY && addr_ok && page_open;
	wire [7:0] sec_idx = flash_addr_high - FIAP_SECURE_BASE;
	wire is_secure = cmd == FIAP_CMD_SECURE_PAGE && flash_addr_high >= FIAP_SECURE_BASE
		&& sec_idx < 8'(FIAP_PAGE_COUNT);
	wire is_clkdbl = cmd == FIAP_CMD_OPTION && flash_addr_high == FIAP_OPT_CLK_DOUBLE;
	wire is_id     = cmd == FIAP_CMD_IDENTIFICATION_READ;
	wire needs_osc = is_chip || is_part0 || is_sector || is_prog || is_secure || is_clkdbl;
	wire is_valid  = needs_osc || is_verify || is_id;
	wire [ADDR_W-1:0] sec_base = tgt & ~ADDR_W'(SECTOR_BYTES - 1);
	wire [ADDR_W-1:0] next_sweep_start = is_sector ? sec_base : '0;
	wire [ADDR_W-1:0] next_sweep_end = is_sector ? sec_base + ADDR_W'(SECTOR_BYTES - 1)
		: ADDR_W'(PART0_BYTES - 1);
	wire [7:0] id_byte = (flash_addr_low == FIAP_ID_ADDR_MFR) ? ID_MFR :
		(flash_addr_low == FIAP_ID_ADDR_DEV) ? ID_DEV :
		(flash_addr_low == FIAP_ID_ADDR_EXT) ? ID_EXT : FIAP_ERASED_BYTE;
	wire [6:0] cur = flash_command[6:0];
	wire [7:0] status = {(!idle), 6'h00, fail_flag};
	wire [7:0] next_rdata =
		(sfr_addr == FIAP_ADDR_COMMAND)   ? flash_command :
		(sfr_addr == FIAP_ADDR_CONFIG)    ? flash_config_reg :
		(sfr_addr == FIAP_ADDR_ADDR_HIGH) ? flash_addr_high :
		(sfr_addr == FIAP_ADDR_ADDR_LOW)  ? flash_addr_low :
		(sfr_addr == FIAP_ADDR_DATA)      ? flash_data_reg :
		(sfr_addr == FIAP_ADDR_STATUS)    ? status : 8'h00;

	fiap_osc_timer #(
		.TICK_CYC (FIAP_OSC_TICK_CYC),
		.CNT_W    (FIAP_TICK_W)
	) u_timer (
		.core_clk (core_clk),
		.rst_n    (rst_s),
		.osc_on   (osc_enable),
		.start    (timer_start),
		.ticks    (op_ticks),
		.expired  (timer_done)
	);

	// feed sequence tracker; any other write breaks it
	always_ff @(posedge core_clk or negedge rst_s) begin
		if (!rst_s)
			feed_stage <= 2'd0;
		else if (sfr_wr) begin
			if (wr_key1 && sfr_wdata == FIAP_KEY_FIRST)
				feed_stage <= 2'd1;
			else if (wr_key2 && sfr_wdata == FIAP_KEY_SECOND && feed_stage == 2'd1)
				feed_stage <= 2'd2;
			else
				feed_stage <= 2'd0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_s) begin
		if (!rst_s) begin
			sfr_rdata <= 8'h00;
			flash_config_reg <= FIAP_CONFIG_RESET;
			flash_addr_high <= 8'h00;
			flash_addr_low <= 8'h00;
		end else begin
			if (sfr_rd)
				sfr_rdata <= next_rdata;
			if (wr_cfg)
				flash_config_reg <= sfr_wdata;
			if (wr_ah && idle)
				flash_addr_high <= sfr_wdata;
			if (wr_al && idle)
				flash_addr_low <= sfr_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (state == FIAP_SWEEP)
			flash_mem[sweep_addr] <= FIAP_ERASED_BYTE;
		else if (state == FIAP_EXEC && cur == FIAP_CMD_BYTE_PROG)
			flash_mem[tgt] <= flash_mem[tgt] & flash_data_reg;
	end

	always_ff @(posedge core_clk or negedge rst_s) begin
		if (!rst_s) begin
			state <= FIAP_IDLE;
			flash_command <= 8'h00;
			flash_data_reg <= 8'h00;
			fail_flag <= 1'b0;
			page_sec <= FIAP_PAGE_SEC_RESET;
			clock_double <= 1'b0;
			boot_vector <= LARGE_PART ? FIAP_BOOT_LARGE : FIAP_BOOT_SMALL;
			cpu_stall <= 1'b0;
			osc_enable <= 1'b0;
			clk_from_external <= 1'b0;
			sweep_addr <= '0;
			sweep_end <= '0;
			op_ticks <= '0;
			timer_start <= 1'b0;
			page_unlocked <= FIAP_PAGE_SEC_RESET;
		end else begin
			timer_start <= 1'b0;
			page_unlocked <= page_sec;
			clk_from_external <= iap_en;
			if (wr_dt && idle)
				flash_data_reg <= sfr_wdata;
			case (state)
				FIAP_IDLE: begin
					if (launch) begin
						flash_command <= sfr_wdata;
						fail_flag <= !is_valid;
						if (is_valid) begin
							state <= FIAP_EXEC;
							cpu_stall <= 1'b1;
							osc_enable <= needs_osc;
							sweep_addr <= next_sweep_start;
							sweep_end <= next_sweep_end;
							op_ticks <= FIAP_TICK_W'(is_prog ? FIAP_PROG_TICKS : FIAP_ERASE_TICKS);
						end
					end
				end
				FIAP_EXEC: begin
					state <= FIAP_WAIT;
					timer_start <= osc_enable;
					case (cur)
						FIAP_CMD_BYTE_VERIFY: flash_data_reg <= flash_mem[tgt];
						FIAP_CMD_IDENTIFICATION_READ: flash_data_reg <= id_byte;
						FIAP_CMD_SECURE_PAGE: page_sec[sec_idx[2:0]] <= 1'b0;
						FIAP_CMD_OPTION: clock_double <= 1'b1;
						FIAP_CMD_CHIP_ERASE: begin
							page_sec <= FIAP_PAGE_SEC_RESET;
							clock_double <= 1'b0;
							boot_vector <= LARGE_PART ? FIAP_BOOT_LARGE : FIAP_BOOT_SMALL;
						end
						FIAP_CMD_PART0_ERASE: page_sec[3:0] <= 4'hf;
						default: ;
					endcase
				end
				FIAP_WAIT: begin
					if (!osc_enable)
						state <= FIAP_DONE;
					else if (timer_done) begin
						if (cur == FIAP_CMD_CHIP_ERASE || cur == FIAP_CMD_PART0_ERASE
							|| cur == FIAP_CMD_SECTOR_ERASE)
							state <= FIAP_SWEEP;
						else
							state <= FIAP_DONE;
					end
				end
				FIAP_SWEEP: begin
					sweep_addr <= sweep_addr + 1'b1;
					if (sweep_addr == sweep_end)
						state <= FIAP_DONE;
				end
				FIAP_DONE: begin
					state <= FIAP_IDLE;
					osc_enable <= 1'b0;
					cpu_stall <= 1'b0;
				end
				default: state <= FIAP_IDLE;
			endcase
		end
	end
endmodule

// [fiap_mailbox_monitor.sv]
// port checker for the mailbox sequencer
`timescale 1ns/1ps
module fiap_mailbox_monitor (
	input wire logic                                core_clk,
	input wire logic                                reset_n,
	input wire logic                                sfr_wr,
	input wire logic                                sfr_rd,
	input wire logic [7:0]                          sfr_addr,
	input wire logic [7:0]                          sfr_wdata,
	input wire logic [7:0]                          sfr_rdata,
	input wire logic                                external_access_select,
	input wire logic                                cpu_stall,
	input wire logic                                osc_enable,
	input wire logic                                clk_from_external,
	input wire logic                                clock_double,
	input wire logic [15:0]                         boot_vector,
	input wire logic [fiap_pkg::FIAP_PAGE_COUNT-1:0] page_unlocked
);
	import fiap_pkg::*;
	wire cmd_wr  = sfr_wr && sfr_addr == FIAP_ADDR_COMMAND;
	wire key1_wr = sfr_wr && sfr_addr == FIAP_ADDR_KEY_FIRST && sfr_wdata == FIAP_KEY_FIRST;
	wire key2_wr = sfr_wr && sfr_addr == FIAP_ADDR_KEY_SECOND && sfr_wdata == FIAP_KEY_SECOND;
	wire ea_held = external_access_select;
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	property p_launch; $rose(cpu_stall) |-> $past(cmd_wr); endproperty
	a_launch: assert property (p_launch) else $error("stall without command write");
	property p_feed; $rose(cpu_stall) |-> $past(key2_wr, 2) && $past(key1_wr, 3); endproperty
	a_feed: assert property (p_feed) else $error("stall without key feed");
	property p_osc; osc_enable |-> cpu_stall; endproperty
	a_osc: assert property (p_osc) else $error("oscillator on outside an operation");
	property p_ext; cpu_stall |-> clk_from_external; endproperty
	a_ext: assert property (p_ext) else $error("operation not on external clock");
	property p_busy;
		sfr_rd && sfr_addr == FIAP_ADDR_STATUS |=> sfr_rdata[FIAP_ST_BUSY_BIT] == $past(cpu_stall);
	endproperty
	a_busy: assert property (p_busy) else $error("busy bit differs from stall");
	property p_ea;
		cmd_wr && sfr_wdata[6:0] == FIAP_CMD_CHIP_ERASE && !cpu_stall && ea_held && $past(ea_held)
			&& $past(ea_held, 2) && $past(ea_held, 3) |=> !cpu_stall;
	endproperty
	a_ea: assert property (p_ea) else $error("chip erase ran with external access high");
	property p_dbl; $rose(clock_double) |-> $past(cpu_stall) || $past(cpu_stall, 2); endproperty
	a_dbl: assert property (p_dbl) else $error("clock double set outside an operation");
	property p_page;
		$changed(page_unlocked) |-> $past(cpu_stall) || $past(cpu_stall, 2) || $past(cpu_stall, 3);
	endproperty
	a_page: assert property (p_page) else $error("page lock moved outside an operation");
endmodule
bind fiap_mailbox fiap_mailbox_monitor mon_u (.core_clk(core_clk), .reset_n(reset_n), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.external_access_select(external_access_select), .cpu_stall(cpu_stall), .osc_enable(osc_enable),
	.clk_from_external(clk_from_external), .clock_double(clock_double), .boot_vector(boot_vector),
	.page_unlocked(page_unlocked));

// [fiap_mailbox_tb.sv]
// self-checking bench for the mailbox sequencer
`timescale 1ns/1ps
module fiap_mailbox_tb;
	import fiap_pkg::*;
	localparam logic [7:0] ID_V [3] = '{8'h3c, 8'h4d, 8'h5e}; // arbitrary signature values
	logic core_clk, reset_n, sfr_wr, sfr_rd, external_access_select, cpu_stall, osc_enable;
	logic clk_from_external, clock_double, rd_seen;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, a_lo, d1, d2;
	logic [15:0] boot_vector;
	logic [FIAP_PAGE_COUNT-1:0] page_unlocked;
	logic [7:0] exp_q [$];
	int n_mismatch, samples_checked, seed, i, k;
	fiap_mailbox #(.ADDR_W(10), .PART0_BYTES(1024), .ID_MFR(ID_V[0]), .ID_DEV(ID_V[1]), .ID_EXT(ID_V[2])) dut_u (
		.core_clk(core_clk), .reset_n(reset_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .external_access_select(external_access_select),
		.cpu_stall(cpu_stall), .osc_enable(osc_enable), .clk_from_external(clk_from_external),
		.clock_double(clock_double), .boot_vector(boot_vector), .page_unlocked(page_unlocked));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic idle();
		@(negedge core_clk);
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge core_clk);
		sfr_wr = 1'b0;
		sfr_rd = 1'b1;
		sfr_addr = a;
		exp_q.push_back(e);
		idle();
	endtask
	task automatic op(input logic [6:0] c, input logic [7:0] ah, input logic [7:0] al, input logic [7:0] dt,
		input bit pk);
		wr(FIAP_ADDR_ADDR_HIGH, ah);
		wr(FIAP_ADDR_ADDR_LOW, al);
		wr(FIAP_ADDR_DATA, dt);
		wr(FIAP_ADDR_KEY_FIRST, FIAP_KEY_FIRST);
		wr(FIAP_ADDR_KEY_SECOND, FIAP_KEY_SECOND);
		wr(FIAP_ADDR_COMMAND, {1'b0, c});
		idle();
		if (pk) begin
			rd(FIAP_ADDR_STATUS, 8'h80);
			chk("cpu_stall", 16'h1, {15'h0, cpu_stall});
			chk("osc_enable", 16'h1, {15'h0, osc_enable});
			chk("clk_from_external", 16'h1, {15'h0, clk_from_external});
		end
		repeat (2) @(negedge core_clk);
		for (i = 0; i < 9000 && cpu_stall !== 1'b0; i++) @(negedge core_clk);
		if (i >= 9000) begin
			n_mismatch++;
			report_and_stop();
		end
		chk("osc_enable", 16'h0, {15'h0, osc_enable});
	endtask
	always @(posedge core_clk) rd_seen <= sfr_rd;
	always @(negedge core_clk) begin
		if (rd_seen === 1'b1 && exp_q.size() > 0) begin
			chk("sfr_rdata", {8'h0, exp_q.pop_front()}, {8'h0, sfr_rdata});
		end
	end
	initial begin
		seed = 32'h0e33;
		{n_mismatch, samples_checked} = '0;
		{reset_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
		external_access_select = 1'b1;
		repeat (2) @(negedge core_clk);
		reset_n = 1'b1;
		repeat (3) @(negedge core_clk);
		chk("page_unlocked", 16'h001f, {11'h0, page_unlocked});
		chk("boot_vector", 16'h4000, boot_vector);
		chk("clock_double", 16'h0, {15'h0, clock_double});
		rd(FIAP_ADDR_STATUS, 8'h00);
		rd(FIAP_ADDR_KEY_FIRST, 8'h00);
		rd(8'h80, 8'h00);
		op(FIAP_CMD_SECURE_PAGE, 8'h90, 8'h00, 8'h00, 0);
		chk("page_unlocked", 16'h001f, {11'h0, page_unlocked});
		wr(FIAP_ADDR_CONFIG, 8'h40);
		op(FIAP_CMD_CHIP_ERASE, 8'h00, 8'h00, FIAP_ERASE_KEY, 0);
		rd(FIAP_ADDR_STATUS, 8'h01);
		external_access_select = 1'b0;
		op(FIAP_CMD_CHIP_ERASE, 8'h00, 8'h00, FIAP_ERASE_KEY, 1);
		external_access_select = 1'b1;
		chk("page_unlocked", 16'h001f, {11'h0, page_unlocked});
		chk("boot_vector", 16'h4000, boot_vector);
		a_lo = $random(seed);
		d1 = $random(seed);
		d2 = $random(seed);
		op(FIAP_CMD_BYTE_PROG, 8'h01, a_lo, d1, 1);
		op(FIAP_CMD_BYTE_PROG, 8'h00, 8'h10, d1, 0);
		op(FIAP_CMD_BYTE_VERIFY, 8'h01, a_lo, 8'h00, 0);
		rd(FIAP_ADDR_DATA, d1);
		op(FIAP_CMD_BYTE_PROG, 8'h01, a_lo, d2, 0);
		op(FIAP_CMD_BYTE_VERIFY, 8'h01, a_lo, 8'h00, 0);
		rd(FIAP_ADDR_DATA, d1 & d2);
		op(FIAP_CMD_SECTOR_ERASE, 8'h01, a_lo ^ 8'h01, 8'h00, 1);
		op(FIAP_CMD_BYTE_VERIFY, 8'h01, a_lo, 8'h00, 0);
		rd(FIAP_ADDR_DATA, 8'hff);
		op(FIAP_CMD_BYTE_VERIFY, 8'h00, 8'h10, 8'h00, 0);
		rd(FIAP_ADDR_DATA, d1);
		wr(FIAP_ADDR_KEY_FIRST, FIAP_KEY_FIRST);
		wr(FIAP_ADDR_DATA, 8'h00);
		wr(FIAP_ADDR_KEY_SECOND, FIAP_KEY_SECOND);
		wr(FIAP_ADDR_COMMAND, {1'b0, FIAP_CMD_BYTE_PROG});
		idle();
		op(FIAP_CMD_BYTE_VERIFY, 8'h00, 8'h10, 8'h00, 0);
		rd(FIAP_ADDR_DATA, d1);
		op(FIAP_CMD_SECURE_PAGE, 8'h91, 8'h00, 8'h00, 1);
		chk("page_unlocked", 16'h001d, {11'h0, page_unlocked});
		op(FIAP_CMD_BYTE_PROG, 8'h01, a_lo, 8'h00, 0);
		rd(FIAP_ADDR_STATUS, 8'h01);
		op(FIAP_CMD_SECURE_PAGE, 8'h90, 8'h00, 8'h00, 0);
		op(FIAP_CMD_PART0_ERASE, 8'h00, 8'h00, FIAP_ERASE_KEY, 0);
		chk("page_unlocked", 16'h001f, {11'h0, page_unlocked});
		op(FIAP_CMD_BYTE_VERIFY, 8'h00, 8'h10, 8'h00, 0);
		rd(FIAP_ADDR_DATA, 8'hff);
		op(FIAP_CMD_OPTION, FIAP_OPT_CLK_DOUBLE, 8'h00, 8'h00, 0);
		chk("clock_double", 16'h1, {15'h0, clock_double});
		for (k = 0; k < 3; k++) begin
			op(FIAP_CMD_IDENTIFICATION_READ, 8'h00, 8'h30 + 8'(k), 8'h00, 0);
			rd(FIAP_ADDR_DATA, ID_V[k]);
		end
		repeat (3) idle();
		chk("pending reads", 16'h0, 16'(exp_q.size()));
		report_and_stop();
	end
endmodule
